// *** hdl/pllcs_pkg.sv ***
// Constants shared by the clock-source and PLL control block.
// Assumes an 8-bit register port with byte offsets as printed.
`default_nettype none

package pllcs_pkg;
    // Register offsets
    localparam logic [9:0] ADDR_PLL_CTRL = 10'h010; // Power, pump mode, polarity
    localparam logic [9:0] ADDR_ABL_CTRL = 10'h017; // Antibacklash width, pump current
    localparam logic [9:0] ADDR_CAL_CTRL = 10'h018; // Calibrate bit
    localparam logic [9:0] ADDR_DIV_RATIO = 10'h1e0; // VCO divider code
    localparam logic [9:0] ADDR_SRC_SEL = 10'h1e1; // Bypass and source select
    localparam logic [9:0] ADDR_UPDATE = 10'h232; // Update trigger
    localparam logic [9:0] ADDR_STATUS = 10'h01f; // Calibration status, read only
    localparam logic [7:0] UPDATE_CODE = 8'h01; // Value that applies staged settings

    // Reset values
    localparam logic [7:0] RST_PLL_CTRL = 8'h01; // PLL powered down
    localparam logic [7:0] RST_ABL_CTRL = 8'h00;
    localparam logic [7:0] RST_CAL_CTRL = 8'h00;
    localparam logic [7:0] RST_DIV_RATIO = 8'h02; // Divide by four
    localparam logic [7:0] RST_SRC_SEL = 8'h00; // External input through divider

    // Field positions
    localparam int PWR_LSB = 0; // Two-bit power field
    localparam int CPM_LSB = 4; // Two-bit pump mode field
    localparam int POL_BIT = 7;
    localparam int ABL_LSB = 0; // Two-bit antibacklash field
    localparam int CUR_LSB = 2; // Three-bit pump current field
    localparam int CAL_BIT = 0;
    localparam int BYP_BIT = 0;
    localparam int SRC_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;

    // Field encodings
    localparam logic [1:0] PWR_ON = 2'h0;
    localparam logic [1:0] PWR_DOWN = 2'h1;
    localparam logic [1:0] CPM_HIZ = 2'h0;
    localparam logic [1:0] CPM_UP = 2'h1;
    localparam logic [1:0] CPM_DOWN = 2'h2;
    localparam logic [1:0] CPM_NORMAL = 2'h3;
    localparam logic [2:0] DIV_MAX_CODE = 3'h4; // Codes 0..4 divide by 2..6
    localparam logic [2:0] DIV_CODE_OFS = 3'h2; // Ratio is code plus two

    // Calibration run length in clock cycles
    localparam int CAL_CYCLES = 64;
endpackage

`default_nettype wire

// *** hdl/pllcs_top.sv ***
// Control logic for clock-source selection, VCO divider and PLL setup.
// Assumes a host on the same clock drives the register port; the source,
// reference and feedback edges arrive from pins and are synchronised here.
//
// How it works
// - Power field 00 runs PLL, 01 powers down
// - Bypass bit 0 uses divider, 1 skips it
// - Source bit 1 internal VCO, 0 external input
// - Divider field selects ratio two to six
// - Calibrate bit going 0 to 1 on update starts calibration
// - Settings apply only on update write 0x01
// - Polarity bit 0 positive, 1 negative
// - Polarity acts only with external VCO
// - Two-bit field sets antibacklash pulse width
// - Pump mode: hiz, force up, down, normal
// - Pump current has eight equal steps
// - PFD compares reference and feedback edges
// - Reset: PLL off, external input, divide four
//
// Added by the designer: strobed register access.
`default_nettype none

module pllcs_top
    import pllcs_pkg::*;
#(
    parameter int CAL_LEN = pllcs_pkg::CAL_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clk_en,
    input wire logic [9:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    input wire logic i_clkin_edge,
    input wire logic i_vco_edge,
    input wire logic i_ref_div,
    input wire logic i_fb_div,
    output logic o_dist_tick,
    output logic o_pll_pdn,
    output logic o_src_vco,
    output logic o_div_bypass,
    output logic [2:0] o_div_ratio,
    output logic o_cp_up,
    output logic o_cp_dn,
    output logic o_cp_hiz,
    output logic [2:0] o_cp_current,
    output logic o_cal_busy
);
    import pllcs_pkg::*;

    localparam int CW = $clog2(CAL_LEN + 1);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0] stg_pll; // Staged copies, written by the host
        logic [7:0] stg_abl;
        logic [7:0] stg_cal;
        logic [7:0] stg_div;
        logic [7:0] stg_src;
        logic [7:0] act_pll; // Active copies, steering the logic
        logic [7:0] act_abl;
        logic [7:0] act_cal;
        logic [7:0] act_div;
        logic [7:0] act_src;
        logic pll_pdn; // Power-down level, kept in step with act_pll
        logic cal_busy;
        logic cal_done;
        logic [CW-1:0] cal_cnt;
        logic [2:0] sy_clk; // Two sync stages, then the edge history
        logic [2:0] sy_vco;
        logic [2:0] sy_ref;
        logic [2:0] sy_fb;
        logic [2:0] div_cnt;
        logic pfd_up;
        logic pfd_dn;
        logic [1:0] abl_cnt;
        logic [7:0] rd_data;
        logic dist_tick;
        logic cp_up;
        logic cp_dn;
        logic cp_hiz;
    } pllcs_state_t;

    pllcs_state_t q_reg; // Registered state
    pllcs_state_t q_next; // Next state

    // Decoded strobes and active fields
    logic wr_upd;
    logic src_tick;
    logic ext_src;
    logic neg_pol;
    logic [1:0] cp_mode;
    logic div_static;
    logic [2:0] ratio_m1;

    ////////////////////////////////////////////////////////////////////////
    // Decode of active settings
    always_comb begin
        wr_upd = i_wr && (i_addr == ADDR_UPDATE) && (i_wr_data == UPDATE_CODE);
        ext_src = !q_reg.act_src[SRC_BIT];
        neg_pol = q_reg.act_pll[POL_BIT] && ext_src;
        cp_mode = q_reg.act_pll[CPM_LSB +: 2];
        // Codes above the top ratio leave the divider static
        div_static = q_reg.act_div[2:0] > DIV_MAX_CODE;
        ratio_m1 = q_reg.act_div[2:0] + DIV_CODE_OFS - 3'h1;
        // Internal VCO gives no edges while the PLL is powered down
        if (ext_src) begin
            src_tick = q_reg.sy_clk[1] && !q_reg.sy_clk[2];
        end else begin
            src_tick = q_reg.sy_vco[1] && !q_reg.sy_vco[2] &&
                (q_reg.act_pll[PWR_LSB +: 2] == PWR_ON);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        q_next = q_reg;
        // Pin synchronisers; stage 0 feeds only stage 1
        q_next.sy_clk = {q_reg.sy_clk[1:0], i_clkin_edge};
        q_next.sy_vco = {q_reg.sy_vco[1:0], i_vco_edge};
        q_next.sy_ref = {q_reg.sy_ref[1:0], i_ref_div};
        q_next.sy_fb = {q_reg.sy_fb[1:0], i_fb_div};

        // Register writes land in staging only
        if (i_wr) begin
            unique case (i_addr)
                ADDR_PLL_CTRL: q_next.stg_pll = i_wr_data;
                ADDR_ABL_CTRL: q_next.stg_abl = i_wr_data;
                ADDR_CAL_CTRL: q_next.stg_cal = i_wr_data;
                ADDR_DIV_RATIO: q_next.stg_div = i_wr_data;
                ADDR_SRC_SEL: q_next.stg_src = i_wr_data;
                default: ;
            endcase
        end

        // Update copies every staged value at once, so no half-applied setup
        if (wr_upd) begin
            q_next.act_pll = q_reg.stg_pll;
            q_next.act_abl = q_reg.stg_abl;
            q_next.act_cal = q_reg.stg_cal;
            q_next.act_div = q_reg.stg_div;
            q_next.act_src = q_reg.stg_src;
        end
        // Registered here so the output pin has no decode behind it
        q_next.pll_pdn = q_next.act_pll[PWR_LSB +: 2] != PWR_ON;

        // Calibration starts on the update that turns the bit on
        if (q_reg.cal_busy) begin
            if (q_reg.cal_cnt == CW'(1)) begin
                q_next.cal_busy = 1'b0;
                q_next.cal_done = 1'b1;
            end
            q_next.cal_cnt = q_reg.cal_cnt - CW'(1);
        end
        if (wr_upd && q_reg.stg_cal[CAL_BIT] && !q_reg.act_cal[CAL_BIT]) begin
            q_next.cal_busy = 1'b1;
            q_next.cal_done = 1'b0;
            q_next.cal_cnt = CW'(CAL_LEN);
        end

        // VCO divider or bypass toward distribution
        q_next.dist_tick = 1'b0;
        if (q_reg.act_src[BYP_BIT]) begin
            q_next.dist_tick = src_tick;
            q_next.div_cnt = 3'h0;
        end else if (div_static) begin
            q_next.div_cnt = 3'h0;
        end else if (src_tick) begin
            if (q_reg.div_cnt >= ratio_m1) begin
                q_next.div_cnt = 3'h0;
                q_next.dist_tick = 1'b1;
            end else begin
                q_next.div_cnt = q_reg.div_cnt + 3'h1;
            end
        end

        // Phase detector: both set starts reset pulse; a fresh edge wins over it
        if (q_reg.pfd_up && q_reg.pfd_dn) begin
            // Overlap lasts field+1 cycles to remove the dead zone
            if (q_reg.abl_cnt == q_reg.act_abl[ABL_LSB +: 2]) begin
                q_next.pfd_up = 1'b0;
                q_next.pfd_dn = 1'b0;
                q_next.abl_cnt = 2'h0;
            end else begin
                q_next.abl_cnt = q_reg.abl_cnt + 2'h1;
            end
        end
        // Edges are applied last so one landing on the clear cycle is kept
        if (q_reg.sy_ref[1] && !q_reg.sy_ref[2]) begin
            q_next.pfd_up = 1'b1;
        end
        if (q_reg.sy_fb[1] && !q_reg.sy_fb[2]) begin
            q_next.pfd_dn = 1'b1;
        end

        // Charge pump drive from mode, power and polarity
        q_next.cp_hiz = 1'b0;
        q_next.cp_up = 1'b0;
        q_next.cp_dn = 1'b0;
        if (q_reg.act_pll[PWR_LSB +: 2] != PWR_ON) begin
            q_next.cp_hiz = 1'b1;
        end else begin
            unique case (cp_mode)
                CPM_HIZ: q_next.cp_hiz = 1'b1;
                CPM_UP: q_next.cp_up = 1'b1;
                CPM_DOWN: q_next.cp_dn = 1'b1;
                CPM_NORMAL: begin
                    q_next.cp_up = neg_pol ? q_reg.pfd_dn : q_reg.pfd_up;
                    q_next.cp_dn = neg_pol ? q_reg.pfd_up : q_reg.pfd_dn;
                end
            endcase
        end

        // Read port: staged values read back, status shows calibration
        q_next.rd_data = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_PLL_CTRL: q_next.rd_data = q_reg.stg_pll;
                ADDR_ABL_CTRL: q_next.rd_data = q_reg.stg_abl;
                ADDR_CAL_CTRL: q_next.rd_data = q_reg.stg_cal;
                ADDR_DIV_RATIO: q_next.rd_data = q_reg.stg_div;
                ADDR_SRC_SEL: q_next.rd_data = q_reg.stg_src;
                ADDR_STATUS: begin
                    q_next.rd_data[ST_BUSY_BIT] = q_reg.cal_busy;
                    q_next.rd_data[ST_DONE_BIT] = q_reg.cal_done;
                end
                default: q_next.rd_data = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; the clock enable freezes everything
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            q_reg <= '0;
            q_reg.stg_pll <= RST_PLL_CTRL;
            q_reg.stg_abl <= RST_ABL_CTRL;
            q_reg.stg_cal <= RST_CAL_CTRL;
            q_reg.stg_div <= RST_DIV_RATIO;
            q_reg.stg_src <= RST_SRC_SEL;
            q_reg.act_pll <= RST_PLL_CTRL;
            q_reg.act_abl <= RST_ABL_CTRL;
            q_reg.act_cal <= RST_CAL_CTRL;
            q_reg.act_div <= RST_DIV_RATIO;
            q_reg.act_src <= RST_SRC_SEL;
            q_reg.pll_pdn <= 1'b1;
            q_reg.cp_hiz <= 1'b1;
        end else if (i_clk_en) begin
            q_reg <= q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from state bits
    assign o_rd_data = q_reg.rd_data;
    assign o_dist_tick = q_reg.dist_tick;
    assign o_pll_pdn = q_reg.pll_pdn;
    assign o_src_vco = q_reg.act_src[SRC_BIT];
    assign o_div_bypass = q_reg.act_src[BYP_BIT];
    assign o_div_ratio = q_reg.act_div[2:0];
    assign o_cp_up = q_reg.cp_up;
    assign o_cp_dn = q_reg.cp_dn;
    assign o_cp_hiz = q_reg.cp_hiz;
    assign o_cp_current = q_reg.act_abl[CUR_LSB +: 3];
    assign o_cal_busy = q_reg.cal_busy;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst || !i_clk_en);

    sequence seq_update;
        wr_upd;
    endsequence
    sequence seq_cal_start;
        seq_update ##0 (q_reg.stg_cal[CAL_BIT] && !q_reg.act_cal[CAL_BIT]);
    endsequence

    a_update_src_apply: assert property (seq_update |=> o_src_vco == $past(q_reg.stg_src[SRC_BIT]))
        else $error("source select not applied on update");
    a_no_early_apply: assert property (!wr_upd |=> $stable(o_src_vco) && $stable(o_div_ratio))
        else $error("active setting changed without update");
    a_pdn_pump_hiz: assert property (o_pll_pdn ##1 o_pll_pdn |-> o_cp_hiz && !o_cp_up && !o_cp_dn)
        else $error("pump driven while powered down");
    a_cal_begins: assert property (seq_cal_start |=> o_cal_busy ##1 o_cal_busy)
        else $error("calibration did not start");
    a_no_bare_cal: assert property (!o_cal_busy && !wr_upd |=> !o_cal_busy)
        else $error("calibration started without update");
    a_bypass_pass: assert property (o_div_bypass && src_tick && !wr_upd |=> o_dist_tick)
        else $error("bypass dropped a source edge");
    a_static_quiet: assert property (div_static && !o_div_bypass && !wr_upd |=> !o_dist_tick)
        else $error("static divider produced output");
    a_abl_width: assert property (q_reg.pfd_up && q_reg.pfd_dn |-> ##[1:4] !(q_reg.pfd_up && q_reg.pfd_dn))
        else $error("antibacklash overlap too long");
    a_force_up: assert property (!o_pll_pdn && cp_mode == CPM_UP && !wr_upd |=> o_cp_up && !o_cp_dn)
        else $error("forced pump-up not driven");
endmodule

`default_nettype wire

// *** tb/pllcs_host.sv ***
// Host model: programs the block's registers over its plain register port.
// Assumes the block shares the clock; every drive follows a rising edge.
`default_nettype none

module pllcs_host
    import pllcs_pkg::*;
(
    input wire logic i_clock,
    output logic [9:0] o_addr,
    output logic [7:0] o_wr_data,
    output logic o_wr,
    output logic o_rd,
    input wire logic [7:0] i_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus from time zero
    initial begin
        o_addr = 10'h000;
        o_wr_data = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-cycle write strobe; the block never stalls
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_wr_data <= d;
        o_wr <= 1'b1;
        @(posedge i_clock);
        o_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clock);
        o_rd <= 1'b0;
        #1 d = i_rd_data;
    endtask

    // Staged values go live only on this exact code
    task automatic update();
        wr(ADDR_UPDATE, UPDATE_CODE);
    endtask

    // Recalibration: clear and apply first, otherwise no new run starts
    task automatic calibrate();
        wr(ADDR_CAL_CTRL, 8'h00);
        update();
        wr(ADDR_CAL_CTRL, 8'h01);
        update();
    endtask

    // With the internal VCO the divider is never bypassed
    task automatic set_source(input logic vco, input logic byp);
        wr(ADDR_SRC_SEL, {6'h00, vco, byp & ~vco});
    endtask
endmodule

`default_nettype wire

// *** tb/pllcs_top_tb_top.sv ***
// Self-checking bench for the clock-source and PLL control block.
// Assumes the host model file and the design package are compiled first.
`default_nettype none

module pllcs_top_tb_top;
    import pllcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int CAL_LEN = 4; // Short calibration keeps the run brief
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1; // Lowered once to prove the freeze
    logic [9:0] addr;
    logic [7:0] wr_data, rd_data, d;
    logic wr, rd, dist_tick, pll_pdn, src_vco, div_bypass, cp_up, cp_dn, cp_hiz, cal_busy;
    logic [2:0] div_ratio, cp_current;
    logic [3:0] pins = 4'h0; // Source in, VCO, reference, feedback
    logic [7:0] st; // Packed view of the static outputs
    int ticks = 0, fails = 0, n_checks = 0;

    assign st = {pll_pdn, src_vco, div_bypass, div_ratio, cp_hiz, cal_busy};

    // 20 MHz clock
    always #25 clock = ~clock;

    // Count every distribution pulse
    always @(posedge clock) if (dist_tick === 1'b1) ticks <= ticks + 1;

    pllcs_host i_pllcs_host (.i_clock(clock), .o_addr(addr), .o_wr_data(wr_data), .o_wr(wr),
        .o_rd(rd), .i_rd_data(rd_data));

    pllcs_top #(.CAL_LEN(CAL_LEN)) i_pllcs_top (.i_clock(clock), .i_srst(srst), .i_clk_en(clk_en),
        .i_addr(addr), .i_wr_data(wr_data), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data),
        .i_clkin_edge(pins[0]), .i_vco_edge(pins[1]), .i_ref_div(pins[2]), .i_fb_div(pins[3]),
        .o_dist_tick(dist_tick), .o_pll_pdn(pll_pdn), .o_src_vco(src_vco), .o_div_bypass(div_bypass),
        .o_div_ratio(div_ratio), .o_cp_up(cp_up), .o_cp_dn(cp_dn), .o_cp_hiz(cp_hiz),
        .o_cp_current(cp_current), .o_cal_busy(cal_busy));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Rising edges on one pin, six cycles apart (sync needs three)
    task automatic toggle(input int which, input int n);
        repeat (n) begin
            @(posedge clock);
            pins[which] <= 1'b1;
            repeat (3) @(posedge clock);
            pins[which] <= 1'b0;
            repeat (2) @(posedge clock);
        end
    endtask

    // Update, then let the registered outputs and pump drive settle
    task automatic apply();
        i_pllcs_host.update();
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic count_ticks(input int which, input int n, input int exp);
        int t0;
        int dt;
        t0 = ticks;
        toggle(which, n);
        repeat (8) @(posedge clock);
        #1 dt = ticks - t0;
        chk(dt[7:0], exp[7:0], "tick count");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1 chk(st, 8'h8a, "reset outputs");
        i_pllcs_host.rd(ADDR_PLL_CTRL, d);
        chk(d, 8'h01, "power reset");
        i_pllcs_host.rd(ADDR_DIV_RATIO, d);
        chk(d, 8'h02, "divider reset");
        i_pllcs_host.rd(10'h0ff, d);
        chk(d, 8'h00, "unmapped read");
    endtask

    // Staged writes stay invisible until the exact update code arrives
    task automatic t_stage();
        i_pllcs_host.wr(ADDR_PLL_CTRL, 8'h30);
        i_pllcs_host.wr(ADDR_ABL_CTRL, 8'h1f);
        i_pllcs_host.wr(ADDR_DIV_RATIO, 8'h00);
        i_pllcs_host.set_source(1'b1, 1'b0);
        i_pllcs_host.wr(ADDR_UPDATE, 8'h02);
        repeat (3) @(posedge clock);
        #1 chk(st, 8'h8a, "wrong update code");
        i_pllcs_host.rd(ADDR_UPDATE, d);
        chk(d, 8'h00, "update reads zero");
        apply();
        chk(st, 8'h40, "applied outputs");
        chk({5'h00, cp_current}, 8'h07, "pump current");
    endtask

    // Divider ratios, bypass, source choice and power-down gating
    task automatic t_div();
        i_pllcs_host.set_source(1'b0, 1'b0);
        for (int c = 0; c <= 4; c++) begin
            i_pllcs_host.wr(ADDR_DIV_RATIO, 8'(c));
            apply();
            count_ticks(0, 3 * (c + 2), 3);
        end
        i_pllcs_host.wr(ADDR_DIV_RATIO, 8'h05);
        apply();
        count_ticks(0, 4, 0);
        i_pllcs_host.set_source(1'b0, 1'b1);
        apply();
        count_ticks(0, 5, 5);
        i_pllcs_host.wr(ADDR_DIV_RATIO, 8'h00);
        i_pllcs_host.set_source(1'b1, 1'b0);
        apply();
        count_ticks(0, 4, 0);
        count_ticks(1, 4, 2);
        i_pllcs_host.wr(ADDR_PLL_CTRL, 8'h31);
        apply();
        count_ticks(1, 4, 0);
        i_pllcs_host.wr(ADDR_PLL_CTRL, 8'h30);
        apply();
    endtask

    // Called at the edge that takes the update, so the first look is that cycle
    task automatic busy_len(output logic [7:0] n);
        n = 8'h00;
        repeat (12) begin
            #1 if (cal_busy === 1'b1) n++;
            @(posedge clock);
        end
    endtask

    // Calibration starts once per clear-then-set sequence
    task automatic t_cal();
        fork
            toggle(2, 20); // Reference kept running during calibration
        join_none
        i_pllcs_host.wr(ADDR_CAL_CTRL, 8'h01);
        i_pllcs_host.update();
        busy_len(d);
        chk(d, 8'(CAL_LEN), "first calibration");
        i_pllcs_host.rd(ADDR_STATUS, d);
        chk(d & 8'h02, 8'h02, "calibration done");
        i_pllcs_host.update();
        busy_len(d);
        chk(d, 8'h00, "no rerun without clear");
        i_pllcs_host.calibrate();
        busy_len(d);
        chk(d, 8'(CAL_LEN), "recalibration");
        wait fork;
    endtask

    // Pump response per mode, polarity and source: seen bits are {hiz, up, dn}
    task automatic t_pfd();
        logic [7:0] ctl [6] = '{8'h30, 8'hb0, 8'hb0, 8'h10, 8'h20, 8'h00};
        logic vco [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        logic [2:0] exp [6] = '{3'b010, 3'b001, 3'b010, 3'b010, 3'b001, 3'b100};
        logic [2:0] seen;
        for (int i = 0; i < 6; i++) begin
            toggle(3, 1);
            repeat (10) @(posedge clock);
            i_pllcs_host.set_source(vco[i], 1'b0);
            i_pllcs_host.wr(ADDR_PLL_CTRL, ctl[i]);
            apply();
            toggle(2, 1);
            seen = 3'b000;
            repeat (8) begin
                @(posedge clock);
                #1 seen = seen | {cp_hiz, cp_up, cp_dn};
            end
            chk({5'h00, seen}, {5'h00, exp[i]}, "pump drive");
        end
    endtask

    // Clock enable low: a write and an update are both ignored
    task automatic t_freeze();
        @(posedge clock);
        clk_en <= 1'b0;
        i_pllcs_host.wr(ADDR_SRC_SEL, 8'h02);
        i_pllcs_host.update();
        @(posedge clock);
        clk_en <= 1'b1;
        #1 chk({7'h00, src_vco}, 8'h00, "frozen update");
        i_pllcs_host.rd(ADDR_SRC_SEL, d);
        chk(d, 8'h00, "frozen write");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_stage();
        t_div();
        t_cal();
        t_pfd();
        t_freeze();
        end_of_test();
    end

    // Watchdog well beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_of_test();
    end
endmodule

`default_nettype wire
